// File: rtl/slc_lifecycle.sv
// Overview of operation
// - Failed load check aborts, reports, auto-clears
// - Any self-test failure enters critical error
// - Error states block crypto and output
// - Critical error installs only to inactive partition
// - Reboot after recovery loads factory partition zero again
// - Reboot loads factory partition zero, verify, self-test
// - First power-up loads factory partition zero
// - No traffic until initialization completes
// - Approved state held until erase executes or a conditional test fails
// - Heartbeat while approved; loss forces reboot
// - Erase from pin or host message
// - Three pin presses confirm; incomplete aborts
// - Erase message returns immediate receipt
// - Message erase waits configured 0-15 seconds
// - Erase clears both domains, leaves operation
// - Uninstall while operating marks non-active partition empty
// - Reboot resets the activated image back to factory
// - Install while operating runs load check
`timescale 1ns/1ps
`default_nettype none

module slc_lifecycle #(
  parameter int unsigned HB_PERIOD_CYC = slc_pkg::HB_PERIOD_CYC,
  parameter int unsigned HB_TIMEOUT_CYC = slc_pkg::HB_TIMEOUT_CYC,
  parameter int unsigned PRESS_WINDOW_CYC = slc_pkg::PRESS_WINDOW_CYC,
  parameter int unsigned SEC_CYC = slc_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host command port
  input wire logic cmd_valid,
  input wire slc_pkg::slc_cmd_t cmd_op,
  input wire logic [3:0] cmd_arg,
  // Engine results
  input wire logic load_done,
  input wire logic sig_ok,
  input wire logic selftest_done,
  input wire logic selftest_ok,
  input wire logic cond_fail,
  input wire logic install_check_done,
  input wire logic install_check_ok,
  input wire logic hb_ack,
  input wire logic erase_pin,
  // Engine requests
  output logic load_start,
  output logic [1:0] load_part,
  output logic selftest_start,
  output logic install_check_start,
  output logic erase_strobe,
  output logic reboot_req,
  // Status
  output logic crypto_enable,
  output logic data_out_enable,
  output logic traffic_enable,
  output logic heartbeat,
  output logic status_valid,
  output slc_pkg::slc_status_t status_code,
  output logic [1:0] active_part,
  output logic [2:0] part_full
);

  // ****************************************
  // State
  // ****************************************
  slc_pkg::slc_state_t state_ff, nxt_state;
  logic [1:0] active_ff;
  logic [2:0] full_ff;
  logic [1:0] inst_part_ff;
  logic inst_busy_ff;
  logic [3:0] delay_cfg_ff;
  logic [3:0] delay_cnt_ff;
  logic delay_run_ff;
  logic [31:0] sec_cnt_ff;
  logic [1:0] press_ff;
  logic pin_q_ff;
  logic [31:0] press_win_ff;
  logic [31:0] hb_cnt_ff;
  logic [31:0] hb_wd_ff;
  logic st_req_ff, ld_req_ff;
  logic ld_arm_ff;
  logic erase_ff, reboot_ff;
  logic sts_v_ff;
  slc_pkg::slc_status_t sts_ff;

  logic in_op, err_state, pin_rise, erase_go, inactive_free;
  logic [1:0] inactive_part;

  assign in_op = (state_ff == slc_pkg::SLC_ST_APPROVED);
  assign err_state = (state_ff == slc_pkg::SLC_ST_CRITICAL);
  assign pin_rise = erase_pin && !pin_q_ff;
  // Factory image is never a target
  assign inactive_part = (active_ff == slc_pkg::PART_UPD_A) ? slc_pkg::PART_UPD_B
                                                            : slc_pkg::PART_UPD_A;
  assign inactive_free = !full_ff[inactive_part];
  // Pin and timed-message erase share one strobe
  assign erase_go = (in_op && pin_rise && press_ff == 2'(slc_pkg::PRESS_COUNT - 1))
                  || (delay_run_ff && delay_cnt_ff == 4'h0);

  // ****************************************
  // Boot and operating state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      slc_pkg::SLC_ST_LOAD: begin
        if (load_done) begin
          nxt_state = slc_pkg::SLC_ST_VERIFY;
        end
      end
      // Bad signature treated as a failed power-up test
      slc_pkg::SLC_ST_VERIFY: begin
        nxt_state = sig_ok ? slc_pkg::SLC_ST_SELFTEST : slc_pkg::SLC_ST_CRITICAL;
      end
      slc_pkg::SLC_ST_SELFTEST: begin
        if (selftest_done) begin
          nxt_state = selftest_ok ? slc_pkg::SLC_ST_APPROVED
                                  : slc_pkg::SLC_ST_CRITICAL;
        end
      end
      slc_pkg::SLC_ST_APPROVED: begin
        if (erase_go) begin
          nxt_state = slc_pkg::SLC_ST_ERASED;
        end else if (cond_fail) begin
          nxt_state = slc_pkg::SLC_ST_CRITICAL;
        end
      end
      slc_pkg::SLC_ST_CRITICAL: nxt_state = slc_pkg::SLC_ST_CRITICAL;
      slc_pkg::SLC_ST_ERASED: nxt_state = slc_pkg::SLC_ST_ERASED;
    endcase
  end

  // Only the reboot reset leaves critical error or erased
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= slc_pkg::SLC_ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Image load requests
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ld_arm_ff <= 1'b1;
      ld_req_ff <= 1'b0;
      st_req_ff <= 1'b0;
    end else begin
      // One pulse after release, none while reset is held
      ld_arm_ff <= 1'b0;
      ld_req_ff <= ld_arm_ff;
      st_req_ff <= (state_ff == slc_pkg::SLC_ST_VERIFY) && sig_ok;
    end
  end

  // ****************************************
  // Partition table
  // ****************************************
  // Held across reboots only when resetn is a power-on reset; a warm
  // reboot that keeps this table must gate resetn outside the block.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      active_ff <= slc_pkg::PART_FACTORY;
      full_ff <= slc_pkg::PART_FULL_RST;
      inst_busy_ff <= 1'b0;
      inst_part_ff <= slc_pkg::PART_UPD_A;
    end else begin
      if (cmd_valid && !inst_busy_ff && (in_op || err_state)) begin
        unique case (cmd_op)
          slc_pkg::SLC_CMD_INSTALL: begin
            if (inactive_free) begin
              inst_busy_ff <= 1'b1;
              inst_part_ff <= inactive_part;
            end
          end
          slc_pkg::SLC_CMD_ACTIVATE: begin
            if (full_ff[inactive_part]) begin
              active_ff <= inactive_part;
            end
          end
          slc_pkg::SLC_CMD_UNINSTALL: begin
            if (in_op) begin
              full_ff[inactive_part] <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      if (inst_busy_ff && install_check_done) begin
        inst_busy_ff <= 1'b0;
        if (install_check_ok) begin
          full_ff[inst_part_ff] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Status messages
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sts_v_ff <= 1'b0;
      sts_ff <= slc_pkg::SLC_STS_NONE;
    end else begin
      sts_v_ff <= 1'b0;
      // Receipt outranks other status; a clash drops the rest
      // A repeated erase message is answered, the count is not restarted
      if (in_op && cmd_valid && cmd_op == slc_pkg::SLC_CMD_ERASE) begin
        sts_v_ff <= 1'b1;
        sts_ff <= slc_pkg::SLC_STS_ERASE_RECEIPT;
      end else if (inst_busy_ff && install_check_done && !install_check_ok) begin
        sts_v_ff <= 1'b1;
        sts_ff <= slc_pkg::SLC_STS_LOAD_FAIL;
      end else if (!err_state && nxt_state == slc_pkg::SLC_ST_CRITICAL) begin
        sts_v_ff <= 1'b1;
        sts_ff <= slc_pkg::SLC_STS_CRITICAL;
      end
    end
  end

  // ****************************************
  // Erase delay
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      delay_cfg_ff <= slc_pkg::ERASE_DELAY_RST;
      delay_cnt_ff <= 4'h0;
      delay_run_ff <= 1'b0;
      sec_cnt_ff <= 32'h0000_0000;
    end else begin
      if (in_op && cmd_valid && cmd_op == slc_pkg::SLC_CMD_SET_DELAY) begin
        delay_cfg_ff <= cmd_arg;
      end
      // Zero delay still costs one cycle before the strobe
      if (erase_go || !in_op) begin
        delay_run_ff <= 1'b0;
      end else if (cmd_valid && cmd_op == slc_pkg::SLC_CMD_ERASE && !delay_run_ff) begin
        delay_run_ff <= 1'b1;
        delay_cnt_ff <= delay_cfg_ff;
        sec_cnt_ff <= 32'h0000_0000;
      end else if (delay_run_ff) begin
        if (sec_cnt_ff == SEC_CYC - 1) begin
          sec_cnt_ff <= 32'h0000_0000;
          delay_cnt_ff <= delay_cnt_ff - 4'h1;
        end else begin
          sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Erase pin presses
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_q_ff <= 1'b0;
      press_ff <= 2'h0;
      press_win_ff <= 32'h0000_0000;
    end else begin
      pin_q_ff <= erase_pin;
      // Window restarts at every press, so slow presses time out
      if (!in_op || erase_go) begin
        press_ff <= 2'h0;
      end else if (pin_rise) begin
        press_ff <= press_ff + 2'h1;
        press_win_ff <= 32'h0000_0000;
      end else if (press_ff != 2'h0) begin
        if (press_win_ff == PRESS_WINDOW_CYC - 1) begin
          press_ff <= 2'h0;
        end else begin
          press_win_ff <= press_win_ff + 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Heartbeat and watchdog
  // ****************************************
  // A lost acknowledge is the disruption that triggers the reboot
  // Request stays set; only the reboot reset clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hb_cnt_ff <= 32'h0000_0000;
      hb_wd_ff <= 32'h0000_0000;
      reboot_ff <= 1'b0;
    end else begin
      if (in_op) begin
        hb_cnt_ff <= (hb_cnt_ff == HB_PERIOD_CYC - 1) ? 32'h0000_0000
                                                     : hb_cnt_ff + 32'h0000_0001;
        if (hb_ack) begin
          hb_wd_ff <= 32'h0000_0000;
        end else if (hb_wd_ff == HB_TIMEOUT_CYC - 1) begin
          reboot_ff <= 1'b1;
        end else begin
          hb_wd_ff <= hb_wd_ff + 32'h0000_0001;
        end
      end else begin
        hb_cnt_ff <= 32'h0000_0000;
        hb_wd_ff <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Erase strobe
  // ****************************************
  // Registered so the erase engine sees one clean cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      erase_ff <= 1'b0;
    end else begin
      erase_ff <= in_op && erase_go;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign load_start = ld_req_ff;
  assign load_part = active_ff;
  assign selftest_start = st_req_ff;
  assign install_check_start = inst_busy_ff;
  assign erase_strobe = erase_ff;
  assign reboot_req = reboot_ff;
  // Enables follow the state directly, so no error cycle leaks
  assign crypto_enable = in_op;
  assign data_out_enable = in_op;
  assign traffic_enable = in_op;
  assign heartbeat = in_op && (hb_cnt_ff == 32'h0000_0000);
  assign status_valid = sts_v_ff;
  assign status_code = sts_ff;
  assign active_part = active_ff;
  assign part_full = full_ff;

endmodule : slc_lifecycle

`default_nettype wire

// File: rtl/slc_pkg.sv
package slc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HB_PERIOD_MS = 100;
  localparam int unsigned HB_PERIOD_CYC = CLK_HZ / 1000 * HB_PERIOD_MS;
  localparam int unsigned HB_TIMEOUT_MS = 1000;
  localparam int unsigned HB_TIMEOUT_CYC = CLK_HZ / 1000 * HB_TIMEOUT_MS;
  localparam int unsigned PRESS_WINDOW_MS = 2000;
  localparam int unsigned PRESS_WINDOW_CYC = CLK_HZ / 1000 * PRESS_WINDOW_MS;
  localparam int unsigned PRESS_COUNT = 3;

  // ****************************************
  // Partitions and reset values
  // ****************************************
  localparam logic [1:0] PART_FACTORY = 2'h0;
  localparam logic [1:0] PART_UPD_A = 2'h1;
  localparam logic [1:0] PART_UPD_B = 2'h2;
  localparam logic [3:0] ERASE_DELAY_RST = 4'h0;
  localparam logic [2:0] PART_FULL_RST = 3'h1;

  // ****************************************
  // Host commands
  // ****************************************
  typedef enum logic [2:0] {
    SLC_CMD_NONE,
    SLC_CMD_INSTALL,
    SLC_CMD_ACTIVATE,
    SLC_CMD_UNINSTALL,
    SLC_CMD_ERASE,
    SLC_CMD_SET_DELAY
  } slc_cmd_t;

  typedef enum logic [2:0] {
    SLC_ST_LOAD,
    SLC_ST_VERIFY,
    SLC_ST_SELFTEST,
    SLC_ST_APPROVED,
    SLC_ST_CRITICAL,
    SLC_ST_ERASED
  } slc_state_t;

  typedef enum logic [1:0] {
    SLC_STS_NONE,
    SLC_STS_LOAD_FAIL,
    SLC_STS_CRITICAL,
    SLC_STS_ERASE_RECEIPT
  } slc_status_t;

endpackage : slc_pkg

// File: tb/slc_lifecycle_props.sv
`timescale 1ns/1ps
`default_nettype none
module slc_lifecycle_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Inputs watched
  input wire logic cmd_valid,
  input wire slc_pkg::slc_cmd_t cmd_op,
  input wire logic selftest_done,
  input wire logic selftest_ok,
  input wire logic sig_ok,
  input wire logic cond_fail,
  input wire logic install_check_done,
  input wire logic install_check_ok,
  // Outputs watched
  input wire logic selftest_start,
  input wire logic install_check_start,
  input wire logic erase_strobe,
  input wire logic reboot_req,
  input wire logic crypto_enable,
  input wire logic data_out_enable,
  input wire logic traffic_enable,
  input wire logic heartbeat,
  input wire logic status_valid,
  input wire slc_pkg::slc_status_t status_code
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  err_block_a: assert property (status_valid
    && status_code == slc_pkg::SLC_STS_CRITICAL |-> !crypto_enable && !data_out_enable
    && !traffic_enable) else $error("error state not blocked");
  crit_err_a: assert property (cond_fail && crypto_enable |=> !crypto_enable)
    else $error("test failure kept enables");
  fail_stat_a: assert property (install_check_start && install_check_done
    && !install_check_ok |=> status_valid && status_code == slc_pkg::SLC_STS_LOAD_FAIL
    && crypto_enable == $past(crypto_enable)) else $error("load fail not reported");
  erase_rcpt_a: assert property (cmd_valid && cmd_op == slc_pkg::SLC_CMD_ERASE
    && crypto_enable && !install_check_start |=> status_valid
    && status_code == slc_pkg::SLC_STS_ERASE_RECEIPT) else $error("no erase receipt");
  strobe_once_a: assert property (erase_strobe |=> !erase_strobe [*8])
    else $error("erase strobe repeated");
  erase_off_a: assert property (erase_strobe |=> !crypto_enable)
    else $error("operation kept after erase");
  hb_gap_a: assert property (heartbeat |-> crypto_enable ##1 !heartbeat [*8])
    else $error("heartbeat spacing wrong");
  reboot_hold_a: assert property ($rose(reboot_req) |=> reboot_req [*4])
    else $error("reboot request dropped");
  boot_go_a: assert property ($rose(crypto_enable) |-> $past(selftest_done && selftest_ok))
    else $error("approved without self-test");
  st_sig_a: assert property (selftest_start |-> $past(sig_ok) && !crypto_enable)
    else $error("self-test before signature check");
  hold_ap_a: assert property ($fell(crypto_enable) |-> $past(cond_fail)
    || erase_strobe || $past(erase_strobe) || reboot_req) else $error("approved left early");
  cover property ($rose(crypto_enable));
  cover property (erase_strobe);
  cover property ($rose(reboot_req));
  cover property (status_valid && status_code == slc_pkg::SLC_STS_LOAD_FAIL);
endmodule : slc_lifecycle_chk
bind slc_lifecycle slc_lifecycle_chk slc_lifecycle_chk_inst (.clk_sys, .resetn, .cmd_valid,
  .cmd_op, .selftest_done, .selftest_ok, .sig_ok, .cond_fail, .install_check_done,
  .install_check_ok, .selftest_start, .install_check_start, .erase_strobe, .reboot_req,
  .crypto_enable, .data_out_enable, .traffic_enable, .heartbeat, .status_valid, .status_code);
`default_nettype wire

// File: tb/slc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Knobs
  input wire logic [3:0] lat,
  input wire logic ack_on,
  input wire logic sig_good,
  input wire logic st_good,
  // Requests
  input wire logic load_start,
  input wire logic selftest_start,
  input wire logic heartbeat,
  // Answers
  output logic load_done,
  output logic sig_ok,
  output logic selftest_done,
  output logic selftest_ok,
  output logic hb_ack
);
  // ****************************************
  // Loader, self-test and host answers
  // ****************************************
  logic [3:0] cnt_ff;
  logic busy_ff;
  assign sig_ok = sig_good;
  assign selftest_ok = st_good;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      load_done <= 1'b0;
      selftest_done <= 1'b0;
      hb_ack <= 1'b0;
    end else begin
      load_done <= busy_ff && cnt_ff == 4'h0;
      busy_ff <= load_start || (busy_ff && cnt_ff != 4'h0);
      cnt_ff <= load_start ? lat : cnt_ff - {3'h0, cnt_ff != 4'h0};
      selftest_done <= selftest_start;
      // Silence here is how a lost heartbeat is provoked
      hb_ack <= heartbeat && ack_on;
    end
  end
endmodule : slc_host_model
`default_nettype wire

// File: tb/test_slc_lifecycle.sv
`timescale 1ns/1ps
`default_nettype none
module test_slc_lifecycle;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  slc_pkg::slc_cmd_t cmd_op = slc_pkg::SLC_CMD_NONE;
  logic [3:0] cmd_arg = 4'h0;
  logic cond_fail = 1'b0;
  logic install_check_done = 1'b0;
  logic install_check_ok = 1'b0;
  logic erase_pin = 1'b0;
  logic ack_on = 1'b1;
  logic [3:0] lat = 4'h1;
  logic sig_good = 1'b1;
  logic st_good = 1'b1;
  logic load_done, sig_ok, selftest_done, selftest_ok, hb_ack, load_start, selftest_start;
  logic install_check_start, erase_strobe, reboot_req, crypto_enable, data_out_enable;
  logic traffic_enable, heartbeat, status_valid;
  logic [1:0] load_part, active_part;
  logic [2:0] part_full;
  slc_pkg::slc_status_t status_code;
  int bad_count = 0;
  int samples_checked = 0;
  int strobes = 0;
  int tests = 0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (erase_strobe === 1'b1) strobes <= strobes + 1;
  always @(posedge clk_sys) if (selftest_start === 1'b1) tests <= tests + 1;
  // Short counts keep the run small
  slc_lifecycle #(.HB_PERIOD_CYC(10), .HB_TIMEOUT_CYC(50), .PRESS_WINDOW_CYC(20), .SEC_CYC(4))
    slc_lifecycle_inst (.clk_sys, .resetn, .cmd_valid, .cmd_op, .cmd_arg, .load_done, .sig_ok,
    .selftest_done, .selftest_ok, .cond_fail, .install_check_done, .install_check_ok, .hb_ack,
    .erase_pin, .load_start, .load_part, .selftest_start, .install_check_start, .erase_strobe,
    .reboot_req, .crypto_enable, .data_out_enable, .traffic_enable, .heartbeat, .status_valid,
    .status_code, .active_part, .part_full);
  slc_host_model slc_host_model_inst (.clk_sys, .resetn, .lat, .ack_on, .sig_good, .st_good,
    .load_start, .selftest_start, .heartbeat, .load_done, .sig_ok, .selftest_done, .selftest_ok,
    .hb_ack);
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task wait_hi(input int sel, input int lim, output int n);
    logic [3:0] v;
    n = 0;
    v = 4'h0;
    while (v[sel] !== 1'b1) begin
      if (n == lim) begin
        bad_count++;
        $display("Error wait %0d timed out", sel);
        close_out();
      end
      @(negedge clk_sys);
      n++;
      v = {load_start, heartbeat, reboot_req, crypto_enable};
    end
  endtask : wait_hi
  task send(input slc_pkg::slc_cmd_t op, input logic [3:0] arg);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= arg;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask : send
  task reboot(input logic [3:0] l);
    int n;
    @(posedge clk_sys);
    resetn <= 1'b0;
    lat <= l;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("part_full", part_full, 8'h01);
    chk("active_part", active_part, 8'h00);
    @(posedge clk_sys);
    resetn <= 1'b1;
    wait_hi(3, 3, n);
    chk("load_part", load_part, 8'h00);
    chk("traffic", traffic_enable, 8'h00);
    wait_hi(0, 60, n);
    chk("traffic up", traffic_enable, 8'h01);
    chk("data out", data_out_enable, 8'h01);
  endtask : reboot
  task inst(input logic ok);
    send(slc_pkg::SLC_CMD_INSTALL, 4'h0);
    @(negedge clk_sys);
    chk("check start", install_check_start, 8'h01);
    @(posedge clk_sys);
    install_check_done <= 1'b1;
    install_check_ok <= ok;
    @(posedge clk_sys);
    install_check_done <= 1'b0;
    @(negedge clk_sys);
  endtask : inst
  // ****************************************
  // Scenarios
  // ****************************************
  task t_hb;
    int n;
    wait_hi(2, 12, n);
    @(posedge clk_sys);
    ack_on <= 1'b0;
    wait_hi(1, 80, n);
    chk("reboot", reboot_req, 8'h01);
    @(posedge clk_sys);
    ack_on <= 1'b1;
    reboot(4'h2);
    $display("heartbeat test done");
  endtask : t_hb
  task t_fw;
    inst(1'b0);
    chk("fail status", status_valid, 8'h01);
    chk("fail code", status_code, slc_pkg::SLC_STS_LOAD_FAIL);
    chk("still up", crypto_enable, 8'h01);
    inst(1'b1);
    chk("part_full", part_full, 8'h03);
    send(slc_pkg::SLC_CMD_INSTALL, 4'h0);
    @(negedge clk_sys);
    chk("refused", install_check_start, 8'h00);
    send(slc_pkg::SLC_CMD_UNINSTALL, 4'h0);
    @(negedge clk_sys);
    chk("emptied", part_full, 8'h01);
    inst(1'b1);
    send(slc_pkg::SLC_CMD_ACTIVATE, 4'h0);
    @(negedge clk_sys);
    chk("active", active_part, 8'h01);
    chk("old image runs", crypto_enable, 8'h01);
    $display("firmware test done");
  endtask : t_fw
  task t_crit;
    @(posedge clk_sys);
    cond_fail <= 1'b1;
    @(posedge clk_sys);
    cond_fail <= 1'b0;
    @(negedge clk_sys);
    chk("crypto", crypto_enable, 8'h00);
    chk("data out", data_out_enable, 8'h00);
    inst(1'b1);
    chk("part_full", part_full, 8'h07);
    send(slc_pkg::SLC_CMD_ACTIVATE, 4'h0);
    @(negedge clk_sys);
    chk("active", active_part, 8'h02);
    chk("traffic", traffic_enable, 8'h00);
    reboot(4'hf);
    $display("critical test done");
  endtask : t_crit
  task t_msg;
    int n;
    int s;
    for (int d = 0; d <= 3; d += 3) begin
      send(slc_pkg::SLC_CMD_SET_DELAY, 4'(d));
      send(slc_pkg::SLC_CMD_ERASE, 4'h0);
      s = strobes;
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
        if (n == 1) chk("receipt", status_code, slc_pkg::SLC_STS_ERASE_RECEIPT);
        if (n == 100) begin
          bad_count++;
          $display("Error erase strobe timed out");
          close_out();
        end
      end while (erase_strobe !== 1'b1);
      chk("delay", 8'(n >= 4 * d + 1 && n <= 4 * d + 2), 8'h01);
      repeat (5) @(negedge clk_sys);
      chk("strobes", 8'(strobes - s), 8'h01);
      chk("erased", crypto_enable, 8'h00);
      reboot(4'h1);
    end
    $display("message erase test done");
  endtask : t_msg
  task press;
    @(posedge clk_sys);
    erase_pin <= 1'b1;
    @(posedge clk_sys);
    erase_pin <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : press
  task t_pin;
    int s;
    s = strobes;
    press();
    press();
    repeat (25) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("aborted", 8'(strobes - s), 8'h00);
    chk("approved", crypto_enable, 8'h01);
    press();
    press();
    @(negedge clk_sys);
    chk("count cleared", 8'(strobes - s), 8'h00);
    press();
    @(negedge clk_sys);
    chk("pin erase", 8'(strobes - s), 8'h01);
    chk("erased", crypto_enable, 8'h00);
    $display("pin erase test done");
  endtask : t_pin
  task t_boot;
    int t;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      resetn <= 1'b0;
      sig_good <= 1'(k);
      st_good <= 1'b0;
      repeat (7) @(posedge clk_sys);
      resetn <= 1'b1;
      t = tests;
      repeat (20) @(negedge clk_sys);
      chk("boot crypto", crypto_enable, 8'h00);
      chk("boot code", status_code, slc_pkg::SLC_STS_CRITICAL);
      chk("self-tests run", 8'(tests - t), 8'(k));
    end
    $display("boot failure test done");
  endtask : t_boot
  initial begin
    reboot(4'h1);
    t_hb();
    t_fw();
    t_crit();
    t_msg();
    t_pin();
    t_boot();
    close_out();
  end
endmodule : test_slc_lifecycle
`default_nettype wire
